// ===== src/usbepm_pkg.sv
// Shared constants, types and carriers of the endpoint mode responder.
// Assumes a single 250 MHz clock domain shared by every user of this package.
package usbepm_pkg;
  localparam int NUM_EP = 5;
  localparam int EP_W = 3;
  localparam int CNT_W = 6;
  localparam int EP_SIZE = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int ACK_BIT = 4;
  localparam int STALL_BIT = 7;
  localparam logic [7:0] MODE_REG_RST = 8'h00;
  localparam logic [3:0] M_DISABLE = 4'h0;
  localparam logic [3:0] M_NAK_INOUT = 4'h1;
  localparam logic [3:0] M_STATUS_OUT = 4'h2;
  localparam logic [3:0] M_STALL_INOUT = 4'h3;
  localparam logic [3:0] M_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] M_ISO_OUT = 4'h5;
  localparam logic [3:0] M_STATUS_IN = 4'h6;
  localparam logic [3:0] M_ISO_IN = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAK_OUT_STIN = 4'hA;
  localparam logic [3:0] M_ACK_OUT_STIN = 4'hB;
  localparam logic [3:0] M_NAK_IN = 4'hC;
  localparam logic [3:0] M_ACK_IN = 4'hD;
  localparam logic [3:0] M_NAK_IN_STOUT = 4'hE;
  localparam logic [3:0] M_ACK_IN_STOUT = 4'hF;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} usbepm_pid_e;
  typedef enum logic [2:0] {
    ACT_IGNORE, ACT_ACK, ACT_NAK, ACT_STALL, ACT_CHECK, ACT_ALWAYS, ACT_TX0, ACT_TXCNT
  } usbepm_act_e;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} usbepm_hs_e;

  typedef struct packed {
    usbepm_pid_e pid;
    logic [EP_W-1:0] ep;
  } usbepm_tok_s;

  typedef struct packed {
    logic [CNT_W-1:0] len;
    logic data_toggle_bit;
    logic crc_ok;
  } usbepm_rx_s;
endpackage

// ===== src/usbepm_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; read data leave through a register.
`timescale 1ns/100ps
module usbepm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] used_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic in_ready_reg;
  wire logic push = in_valid && in_ready_reg;
  wire logic load = (used_reg != '0) && (!out_valid_reg || out_ready);
  wire logic [AW:0] used_next = used_reg + (AW + 1)'(push) - (AW + 1)'(load);
  wire logic out_valid_next = load || (out_valid_reg && !out_ready);
  wire logic [AW:0] fill_next = used_next + (AW + 1)'(out_valid_next);
  wire logic wrap_w = (wr_ptr_reg == AW'(DEPTH - 1));
  wire logic wrap_r = (rd_ptr_reg == AW'(DEPTH - 1));

  // Full counts the output register too, so exactly DEPTH words fit in all.
  // Ready is registered so the upstream side never sees a combinational path.
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      used_reg <= '0;
      in_ready_reg <= 1'b1;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wrap_w ? '0 : wr_ptr_reg + 1'b1;
      if (load) rd_ptr_reg <= wrap_r ? '0 : rd_ptr_reg + 1'b1;
      used_reg <= used_next;
      in_ready_reg <= (fill_next != (AW + 1)'(DEPTH));
      if (load) begin
        out_data_reg <= mem_reg[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule

// ===== src/usbepm_responder.sv
// Endpoint mode responder of a full-speed serial_interface_engine.
// Assumes token, data and host handshake strobes come from logic on the same clock.
`timescale 1ns/100ps
module usbepm_responder #(
  parameter int NUM_EP = usbepm_pkg::NUM_EP,
  parameter int EP_SIZE = usbepm_pkg::EP_SIZE,
  parameter int FIFO_DEPTH = usbepm_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic fw_mode_wr,
  input wire logic fw_cnt_wr,
  input wire logic [usbepm_pkg::EP_W-1:0] fw_ep,
  input wire logic [7:0] fw_data,
  input wire logic tok_valid,
  input wire usbepm_pkg::usbepm_tok_s tok,
  input wire logic rx_done,
  input wire usbepm_pkg::usbepm_rx_s rx,
  input wire logic host_ack,
  input wire logic host_timeout,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [usbepm_pkg::BYTE_W-1:0] src_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [usbepm_pkg::BYTE_W-1:0] tx_data,
  output logic hs_valid,
  output usbepm_pkg::usbepm_hs_e hs_code,
  output logic [usbepm_pkg::CNT_W-1:0] hs_len,
  output logic hs_toggle,
  output logic ep_irq,
  output logic [usbepm_pkg::EP_W-1:0] ep_irq_num,
  output logic ctl_setup_seen,
  output logic ctl_in_seen,
  output logic ctl_out_seen,
  output logic [NUM_EP*8-1:0] ep_mode_flat
);
  typedef enum logic [1:0] {ST_IDLE, ST_RXWAIT, ST_TX, ST_HSWAIT} usbepm_state_e;

  function automatic usbepm_pkg::usbepm_act_e usbepm_decode(
    input logic [3:0] mode, input usbepm_pkg::usbepm_pid_e pid, input logic stall);
    usbepm_pkg::usbepm_act_e act;
    act = usbepm_pkg::ACT_IGNORE;
    case (pid)
      usbepm_pkg::PID_SETUP: begin
        case (mode)
          4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hE, 4'hF: act = usbepm_pkg::ACT_ACK;
          default: act = usbepm_pkg::ACT_IGNORE;
        endcase
      end
      usbepm_pkg::PID_IN: begin
        case (mode)
          usbepm_pkg::M_NAK_INOUT, usbepm_pkg::M_NAK_IN: act = usbepm_pkg::ACT_NAK;
          usbepm_pkg::M_NAK_IN_STOUT: act = usbepm_pkg::ACT_NAK;
          usbepm_pkg::M_STATUS_OUT, usbepm_pkg::M_STALL_INOUT: act = usbepm_pkg::ACT_STALL;
          usbepm_pkg::M_STATUS_IN, usbepm_pkg::M_NAK_OUT_STIN: act = usbepm_pkg::ACT_TX0;
          usbepm_pkg::M_ACK_OUT_STIN: act = usbepm_pkg::ACT_TX0;
          usbepm_pkg::M_ISO_IN, usbepm_pkg::M_ACK_IN_STOUT: act = usbepm_pkg::ACT_TXCNT;
          usbepm_pkg::M_ACK_IN: act = stall ? usbepm_pkg::ACT_STALL : usbepm_pkg::ACT_TXCNT;
          default: act = usbepm_pkg::ACT_IGNORE;
        endcase
      end
      usbepm_pkg::PID_OUT: begin
        case (mode)
          usbepm_pkg::M_NAK_INOUT, usbepm_pkg::M_NAK_OUT: act = usbepm_pkg::ACT_NAK;
          usbepm_pkg::M_NAK_OUT_STIN: act = usbepm_pkg::ACT_NAK;
          usbepm_pkg::M_STALL_INOUT, usbepm_pkg::M_STATUS_IN: act = usbepm_pkg::ACT_STALL;
          usbepm_pkg::M_STATUS_OUT, usbepm_pkg::M_NAK_IN_STOUT: act = usbepm_pkg::ACT_CHECK;
          usbepm_pkg::M_ACK_IN_STOUT: act = usbepm_pkg::ACT_CHECK;
          usbepm_pkg::M_ISO_OUT: act = usbepm_pkg::ACT_ALWAYS;
          usbepm_pkg::M_ACK_OUT: act = stall ? usbepm_pkg::ACT_STALL : usbepm_pkg::ACT_ACK;
          usbepm_pkg::M_ACK_OUT_STIN: act = usbepm_pkg::ACT_ACK;
          default: act = usbepm_pkg::ACT_IGNORE;
        endcase
      end
      default: act = usbepm_pkg::ACT_IGNORE;
    endcase
    return act;
  endfunction

  // keep nak modes.
  // Modes 1010 and 1110 fall to the default arm on OUT and so keep their value; a SETUP still forces 0001.
  function automatic logic [3:0] usbepm_after_ack(
    input logic [3:0] mode, input usbepm_pkg::usbepm_pid_e pid);
    logic [3:0] nxt;
    nxt = mode;
    case (pid)
      usbepm_pkg::PID_SETUP: nxt = usbepm_pkg::M_NAK_INOUT;
      usbepm_pkg::PID_IN: nxt = (mode == usbepm_pkg::M_ACK_IN) ? usbepm_pkg::M_NAK_IN : mode;
      usbepm_pkg::PID_OUT: begin
        case (mode)
          usbepm_pkg::M_ACK_OUT: nxt = usbepm_pkg::M_NAK_OUT;
          usbepm_pkg::M_ACK_OUT_STIN: nxt = usbepm_pkg::M_NAK_OUT_STIN;
          usbepm_pkg::M_ACK_IN_STOUT: nxt = usbepm_pkg::M_NAK_IN_STOUT;
          default: nxt = mode;
        endcase
      end
      default: nxt = mode;
    endcase
    return nxt;
  endfunction

  usbepm_state_e state_reg;
  usbepm_state_e state_next;
  logic [7:0] mode_reg [NUM_EP];
  logic [usbepm_pkg::CNT_W-1:0] cnt_reg [NUM_EP];
  logic tog_reg [NUM_EP];
  logic [usbepm_pkg::EP_W-1:0] cur_ep_reg;
  usbepm_pkg::usbepm_pid_e cur_pid_reg;
  usbepm_pkg::usbepm_act_e cur_act_reg;
  logic [usbepm_pkg::CNT_W-1:0] left_reg;
  logic hs_valid_reg;
  usbepm_pkg::usbepm_hs_e hs_code_reg;
  logic [usbepm_pkg::CNT_W-1:0] hs_len_reg;
  logic hs_tog_reg;
  logic irq_reg;
  logic [usbepm_pkg::EP_W-1:0] irq_num_reg;
  logic setup_seen_reg;
  logic in_seen_reg;
  logic out_seen_reg;
  logic tx_valid_reg;
  logic [usbepm_pkg::BYTE_W-1:0] tx_data_reg;
  logic f_valid;
  logic [usbepm_pkg::BYTE_W-1:0] f_data;

  wire logic idle = (state_reg == ST_IDLE);
  wire logic take_tok = idle && tok_valid && (int'(tok.ep) < NUM_EP);
  wire logic [7:0] tok_mreg = mode_reg[tok.ep];
  wire usbepm_pkg::usbepm_act_e tok_act =
    usbepm_decode(tok_mreg[3:0], tok.pid, tok_mreg[usbepm_pkg::STALL_BIT]);
  wire logic [3:0] cur_mode = mode_reg[cur_ep_reg][3:0];
  wire logic rxw = (state_reg == ST_RXWAIT) && rx_done;
  wire logic rx_ok = rx.crc_ok && (int'(rx.len) <= EP_SIZE);
  wire logic chk_ok = (rx.len == '0) && rx.data_toggle_bit;
  wire logic rx_ack = rxw && rx_ok && ((cur_act_reg == usbepm_pkg::ACT_ACK) ||
    ((cur_act_reg == usbepm_pkg::ACT_CHECK) && chk_ok));
  wire logic rx_stall = rxw && rx_ok && ((cur_act_reg == usbepm_pkg::ACT_STALL) ||
    ((cur_act_reg == usbepm_pkg::ACT_CHECK) && !chk_ok));
  wire logic rx_nak = rxw && rx_ok && (cur_act_reg == usbepm_pkg::ACT_NAK);
  wire logic in_ack = (state_reg == ST_HSWAIT) && host_ack;
  wire logic ack_evt = rx_ack || in_ack;
  wire logic tok_imm = (tok_act == usbepm_pkg::ACT_NAK) || (tok_act == usbepm_pkg::ACT_STALL);
  wire logic in_hs = take_tok && (tok.pid == usbepm_pkg::PID_IN) && tok_imm;
  wire logic tx_start = take_tok && (tok.pid == usbepm_pkg::PID_IN) &&
    ((tok_act == usbepm_pkg::ACT_TX0) || (tok_act == usbepm_pkg::ACT_TXCNT));
  wire logic [usbepm_pkg::CNT_W-1:0] tx_len =
    (tok_act == usbepm_pkg::ACT_TXCNT) ? cnt_reg[tok.ep] : '0;
  wire logic tx_slot = !tx_valid_reg || tx_ready;
  wire logic f_pop = (state_reg == ST_TX) && (left_reg != '0) && tx_slot && f_valid;
  wire logic tx_end = (state_reg == ST_TX) && ((left_reg == '0) ||
    ((left_reg == 6'h01) && f_pop));
  wire logic iso_in = (cur_mode == usbepm_pkg::M_ISO_IN);
  wire logic done_evt = ack_evt || (rxw && (cur_act_reg == usbepm_pkg::ACT_ALWAYS) && rx_ok) ||
    rx_nak || rx_stall || (tx_end && iso_in);
  // bad crc on out or setup.
  wire logic crc_bad = rxw && !rx.crc_ok;

  usbepm_fifo #(
    .WIDTH(usbepm_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data(src_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // ignored tokens leave the machine idle.
        if (take_tok && (tok_act != usbepm_pkg::ACT_IGNORE)) begin
          if (tok.pid != usbepm_pkg::PID_IN) state_next = ST_RXWAIT;
          else if (tx_start) state_next = ST_TX;
        end
      end
      ST_RXWAIT: if (rx_done) state_next = ST_IDLE;
      ST_TX: if (tx_end) state_next = iso_in ? ST_IDLE : ST_HSWAIT;
      ST_HSWAIT: if (host_ack || host_timeout) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_ep_reg <= '0;
      cur_pid_reg <= usbepm_pkg::PID_SETUP;
      cur_act_reg <= usbepm_pkg::ACT_IGNORE;
    end else if (take_tok) begin
      cur_ep_reg <= tok.ep;
      cur_pid_reg <= tok.pid;
      cur_act_reg <= tok_act;
    end
  end

  // The handshake strobe lasts one cycle; data packets carry length and toggle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hs_valid_reg <= 1'b0;
      hs_code_reg <= usbepm_pkg::HS_ACK;
      hs_len_reg <= '0;
      hs_tog_reg <= 1'b0;
    end else begin
      hs_valid_reg <= rx_ack || rx_stall || rx_nak || in_hs || tx_start;
      if (rx_ack) hs_code_reg <= usbepm_pkg::HS_ACK;
      else if (rx_stall || (in_hs && tok_act == usbepm_pkg::ACT_STALL))
        hs_code_reg <= usbepm_pkg::HS_STALL;
      else if (rx_nak || in_hs) hs_code_reg <= usbepm_pkg::HS_NAK;
      else if (tx_start) hs_code_reg <= usbepm_pkg::HS_DATA;
      if (tx_start) hs_len_reg <= tx_len;
      if (tx_start) hs_tog_reg <= tog_reg[tok.ep];
    end
  end

  // byte stream of exactly the programmed count, or of zero bytes for ACT_TX0.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_reg <= '0;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= '0;
    end else begin
      if (tx_start) left_reg <= tx_len;
      else if (f_pop) left_reg <= left_reg - 1'b1;
      if (f_pop) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg <= f_data;
      end else if (tx_ready) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
      irq_num_reg <= '0;
    end else begin
      irq_reg <= done_evt || crc_bad || in_hs;
      if (in_hs) irq_num_reg <= tok.ep;
      else irq_num_reg <= cur_ep_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      setup_seen_reg <= 1'b0;
      in_seen_reg <= 1'b0;
      out_seen_reg <= 1'b0;
    end else if (take_tok && (tok.ep == '0) && (tok_act != usbepm_pkg::ACT_IGNORE)) begin
      setup_seen_reg <= (tok.pid == usbepm_pkg::PID_SETUP);
      in_seen_reg <= (tok.pid == usbepm_pkg::PID_IN);
      out_seen_reg <= (tok.pid == usbepm_pkg::PID_OUT);
    end
  end

  genvar e;
  generate
    for (e = 0; e < NUM_EP; e++) begin : g_ep
      wire logic fw_hit = fw_mode_wr && (int'(fw_ep) == e);
      wire logic hw_hit = ack_evt && (int'(cur_ep_reg) == e);
      wire logic [7:0] base = fw_hit ? fw_data : mode_reg[e];
      wire logic [3:0] auto_mode = usbepm_after_ack(mode_reg[e][3:0], cur_pid_reg);
      // rewrite lands with the closing handshake; hardware wins bits 4:0 of a same-cycle write, firmware keeps bits 7:5.
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          mode_reg[e] <= usbepm_pkg::MODE_REG_RST;
        end else if (hw_hit) begin
          mode_reg[e] <= {base[7:5], 1'b1, auto_mode};
        end else begin
          mode_reg[e] <= base;
        end
      end
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          cnt_reg[e] <= usbepm_pkg::CNT_RST;
          tog_reg[e] <= 1'b0;
        end else if (fw_cnt_wr && (int'(fw_ep) == e)) begin
          cnt_reg[e] <= fw_data[usbepm_pkg::CNT_W-1:0];
          tog_reg[e] <= fw_data[7];
        end
      end
      assign ep_mode_flat[e*8 +: 8] = mode_reg[e];
    end
  endgenerate

  assign hs_valid = hs_valid_reg;
  assign hs_code = hs_code_reg;
  assign hs_len = hs_len_reg;
  assign hs_toggle = hs_tog_reg;
  assign ep_irq = irq_reg;
  assign ep_irq_num = irq_num_reg;
  assign ctl_setup_seen = setup_seen_reg;
  assign ctl_in_seen = in_seen_reg;
  assign ctl_out_seen = out_seen_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;

  a_ignore_silent: assert property (@(posedge clock) disable iff (!rstn)
    (take_tok && tok_act == usbepm_pkg::ACT_IGNORE) |=> !hs_valid_reg && idle)
    else $error("ignored token drew a handshake");
  a_disable_ignore: assert property (@(posedge clock) disable iff (!rstn)
    (take_tok && tok_mreg[3:0] == usbepm_pkg::M_DISABLE) |=> ##1 !hs_valid_reg)
    else $error("disabled endpoint answered");
  a_setup_acked: assert property (@(posedge clock) disable iff (!rstn)
    (rxw && rx_ok && cur_pid_reg == usbepm_pkg::PID_SETUP) |=>
    hs_valid_reg && hs_code_reg == usbepm_pkg::HS_ACK)
    else $error("valid setup not acked");
  a_setup_nak_mode: assert property (@(posedge clock) disable iff (!rstn)
    (rx_ack && cur_pid_reg == usbepm_pkg::PID_SETUP && !fw_mode_wr) |=>
    mode_reg[$past(cur_ep_reg)][3:0] == usbepm_pkg::M_NAK_INOUT)
    else $error("setup did not force nak mode");
  a_ackout_to_nak: assert property (@(posedge clock) disable iff (!rstn)
    (rx_ack && cur_pid_reg == usbepm_pkg::PID_OUT && cur_mode == usbepm_pkg::M_ACK_OUT) |=>
    mode_reg[$past(cur_ep_reg)][3:0] == usbepm_pkg::M_NAK_OUT)
    else $error("ack out did not fall to nak out");
  a_check_stall: assert property (@(posedge clock) disable iff (!rstn)
    (rxw && rx_ok && cur_act_reg == usbepm_pkg::ACT_CHECK && !chk_ok) |=>
    hs_valid_reg && hs_code_reg == usbepm_pkg::HS_STALL)
    else $error("failed status check not stalled");
  a_tx_count: assert property (@(posedge clock) disable iff (!rstn)
    (tx_start && tok_act == usbepm_pkg::ACT_TXCNT) |=>
    hs_code_reg == usbepm_pkg::HS_DATA && hs_len_reg == $past(cnt_reg[tok.ep]))
    else $error("data length differs from count");
  a_tx_zero: assert property (@(posedge clock) disable iff (!rstn)
    (tx_start && tok_act == usbepm_pkg::ACT_TX0) |=> hs_len_reg == '0 ##1 !tx_valid_reg)
    else $error("zero packet carried payload");
  a_keep_nak_stin: assert property (@(posedge clock) disable iff (!rstn)
    (in_ack && cur_mode == usbepm_pkg::M_NAK_OUT_STIN && !fw_mode_wr) |=>
    mode_reg[$past(cur_ep_reg)][3:0] == usbepm_pkg::M_NAK_OUT_STIN)
    else $error("mode 1010 changed by hardware");
  a_ack_flag: assert property (@(posedge clock) disable iff (!rstn)
    ack_evt |=> mode_reg[$past(cur_ep_reg)][usbepm_pkg::ACK_BIT])
    else $error("ack flag not set");

  c_setup_ack: cover property (@(posedge clock) disable iff (!rstn)
    rx_ack && cur_pid_reg == usbepm_pkg::PID_SETUP);
  c_tx_count: cover property (@(posedge clock) disable iff (!rstn)
    tx_start && tok_act == usbepm_pkg::ACT_TXCNT && tx_len > 6'h02);
  c_in_ack: cover property (@(posedge clock) disable iff (!rstn)
    in_ack && cur_mode == usbepm_pkg::M_ACK_IN);
endmodule

// ===== tb/usbepm_host_model.sv
// Host controller model: tokens, data packets, IN handshakes, byte sink.
// Assumes the responder samples these lines on the rising clock edge.
`timescale 1ns/100ps
module usbepm_host_model (
  input wire logic clock,
  input wire logic slow,
  output logic tok_valid,
  output usbepm_pkg::usbepm_tok_s tok,
  output logic rx_done,
  output usbepm_pkg::usbepm_rx_s rx,
  output logic host_ack,
  output logic tx_ready
);
  logic [1:0] ph = 2'h0;
  initial begin
    tok_valid = 1'b0;
    tok = '0;
    rx_done = 1'b0;
    rx = '0;
    host_ack = 1'b0;
  end
  // A slow host takes a byte only every fourth cycle.
  always @(posedge clock) ph <= ph + 2'h1;
  assign tx_ready = !slow || (ph == 2'h3);
  // Released lines are inverted so a stale value is never read as good.
  task automatic send_tok(input logic [1:0] pid, input logic [2:0] ep);
    @(posedge clock);
    tok_valid <= 1'b1;
    tok <= {pid, ep};
    @(posedge clock);
    tok_valid <= 1'b0;
    tok <= ~{pid, ep};
  endtask
  task automatic send_rx(input logic [5:0] len, input logic tog, input logic crc);
    @(posedge clock);
    rx_done <= 1'b1;
    rx <= {len, tog, crc};
    @(posedge clock);
    rx_done <= 1'b0;
    rx <= ~{len, tog, crc};
  endtask
  task automatic send_ack();
    @(posedge clock);
    host_ack <= 1'b1;
    @(posedge clock);
    host_ack <= 1'b0;
  endtask
endmodule

// ===== tb/usbepm_responder_tb.sv
// Self-checking bench of the endpoint mode responder.
// Assumes the default responder parameters and the host model.
`timescale 1ns/100ps
module usbepm_responder_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic fw_mode_wr = 1'b0;
  logic fw_cnt_wr = 1'b0;
  logic [2:0] fw_ep = 3'h0;
  logic [7:0] fw_data = 8'h00;
  logic src_valid = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic slow = 1'b0;
  logic host_timeout = 1'b0;
  logic tok_valid, rx_done, host_ack, src_ready, tx_valid, tx_ready, hs_valid, ep_irq;
  logic ctl_in_seen, ctl_setup_seen, ctl_out_seen, hs_toggle, hs_t;
  logic [2:0] ep_irq_num, irq_e;
  logic [7:0] tx_data;
  logic [5:0] hs_len, hs_l;
  logic [1:0] hs_c;
  logic [39:0] ep_mode_flat;
  usbepm_pkg::usbepm_tok_s tok;
  usbepm_pkg::usbepm_rx_s rx;
  usbepm_pkg::usbepm_hs_e hs_code;
  logic [7:0] txq[$];
  int bad_count = 0, compares = 0, hs_n = 0, irq_n = 0, cyc = 0, h0, i0;
  logic [19:0] r;
  // Row: mode, stall and token, toggle and length, answer (4 none), mode after.
  logic [19:0] rows [42] = '{
    20'h00040, 20'h01040, 20'h02840, 20'h10001, 20'h11011, 20'h12011, 20'h21022,
    20'h22802, 20'h22022, 20'h30001, 20'h31023, 20'h32023, 20'h41044, 20'h42044,
    20'h40001, 20'h50045, 20'h52345, 20'h51045, 20'h61036, 20'h62026, 20'h72047,
    20'h70047, 20'h82018, 20'h81048, 20'h92008, 20'h9A029, 20'hA201A, 20'hA103A,
    20'hA0001, 20'hB200A, 20'hB103B, 20'hC101C, 20'hC204C, 20'hC004C, 20'hD103C,
    20'hD902D, 20'hE280E, 20'hE101E, 20'hF103F, 20'hF292F, 20'hF280E, 20'hF0001};
  usbepm_responder usbepm_responder_inst (.clock(clock), .rstn(rstn),
    .fw_mode_wr(fw_mode_wr), .fw_cnt_wr(fw_cnt_wr), .fw_ep(fw_ep), .fw_data(fw_data),
    .tok_valid(tok_valid), .tok(tok), .rx_done(rx_done), .rx(rx), .host_ack(host_ack),
    .host_timeout(host_timeout), .src_valid(src_valid), .src_ready(src_ready),
    .src_data(src_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .hs_valid(hs_valid), .hs_code(hs_code), .hs_len(hs_len), .hs_toggle(hs_toggle),
    .ep_irq(ep_irq), .ep_irq_num(ep_irq_num), .ctl_setup_seen(ctl_setup_seen),
    .ctl_in_seen(ctl_in_seen), .ctl_out_seen(ctl_out_seen), .ep_mode_flat(ep_mode_flat));
  usbepm_host_model usbepm_host_model_inst (.clock(clock), .slow(slow),
    .tok_valid(tok_valid), .tok(tok), .rx_done(rx_done), .rx(rx),
    .host_ack(host_ack), .tx_ready(tx_ready));
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fw(input logic m, input logic [2:0] ep, input logic [7:0] d);
    @(posedge clock);
    fw_mode_wr <= m;
    fw_cnt_wr <= !m;
    fw_ep <= ep;
    fw_data <= d;
    @(posedge clock);
    fw_mode_wr <= 1'b0;
    fw_cnt_wr <= 1'b0;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (hs_valid === 1'b1) begin
      hs_n <= hs_n + 1;
      hs_c <= hs_code;
      hs_l <= hs_len;
      hs_t <= hs_toggle;
    end
    if (ep_irq === 1'b1) begin
      irq_n <= irq_n + 1;
      irq_e <= ep_irq_num;
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("reset modes", 8'h00, {7'h0, |ep_mode_flat});
    for (int i = 0; i < 42; i++) begin
      r = rows[i];
      fw(1'b1, 3'h1, {r[15], 3'h0, r[19:16]});
      h0 = hs_n;
      i0 = irq_n;
      usbepm_host_model_inst.send_tok(r[13:12], 3'h1);
      if (r[13:12] != 2'h1) usbepm_host_model_inst.send_rx({3'h0, r[10:8]}, r[11], 1'b1);
      if (r[7:4] == 4'h3) usbepm_host_model_inst.send_ack();
      repeat (6) @(posedge clock);
      chk("answers", {7'h0, r[7:4] != 4'h4}, 8'(hs_n - h0));
      if (r[7:4] != 4'h4) chk("answer code", {6'h0, r[5:4]}, {6'h0, hs_c});
      chk("mode after", {4'h0, r[3:0]}, {4'h0, ep_mode_flat[11:8]});
      if (r[7:4] == 4'h0 || r[7:4] == 4'h3) chk("ack", 8'h01, {7'h0, ep_mode_flat[12]});
      chk("irq", {7'h0, r[7:4] != 4'h4 || r[19:12] == 8'h52}, 8'(irq_n - i0));
    end
    fw(1'b1, 3'h1, 8'h0B);
    h0 = hs_n;
    i0 = irq_n;
    usbepm_host_model_inst.send_tok(2'h2, 3'h1);
    usbepm_host_model_inst.send_rx(6'h00, 1'b1, 1'b0);
    repeat (6) @(posedge clock);
    chk("bad crc", 8'h01, 8'(irq_n - i0 + 2 * (hs_n - h0)));
    fw(1'b1, 3'h0, 8'h01);
    usbepm_host_model_inst.send_tok(2'h1, 3'h0);
    repeat (4) @(posedge clock);
    chk("in seen", 8'h01, {7'h0, ctl_in_seen});
    chk("irq ep", 8'h00, {5'h0, irq_e});
    usbepm_host_model_inst.send_tok(2'h0, 3'h0);
    usbepm_host_model_inst.send_rx(6'h00, 1'b0, 1'b1);
    repeat (4) @(posedge clock);
    chk("setup seen", 8'h04, {5'h0, ctl_setup_seen, ctl_in_seen, ctl_out_seen});
    usbepm_host_model_inst.send_tok(2'h2, 3'h0);
    usbepm_host_model_inst.send_rx(6'h00, 1'b0, 1'b1);
    repeat (4) @(posedge clock);
    chk("out seen", 8'h01, {5'h0, ctl_setup_seen, ctl_in_seen, ctl_out_seen});
    fw(1'b0, 3'h2, 8'h83);
    fw(1'b1, 3'h2, 8'h0D);
    for (int b = 0; b < 8; b++) begin
      src_valid <= 1'b1;
      src_data <= 8'hA0 + 8'(b);
      @(posedge clock);
      while (src_ready !== 1'b1) @(posedge clock);
    end
    src_valid <= 1'b0;
    repeat (2) @(posedge clock);
    chk("fifo full", 8'h00, {7'h0, src_ready});
    slow <= 1'b1;
    usbepm_host_model_inst.send_tok(2'h1, 3'h2);
    repeat (20) @(posedge clock);
    chk("tx len", 8'h03, {2'h0, hs_l});
    chk("tx toggle", 8'h01, {7'h0, hs_t});
    chk("tx count", 8'h03, 8'(txq.size()));
    usbepm_host_model_inst.send_ack();
    repeat (4) @(posedge clock);
    chk("mode after in", 8'h1C, ep_mode_flat[23:16]);
    fw(1'b0, 3'h2, 8'h05);
    fw(1'b1, 3'h2, 8'h07);
    usbepm_host_model_inst.send_tok(2'h1, 3'h2);
    repeat (30) @(posedge clock);
    for (int b = 0; b < 8; b++) chk("tx byte", 8'hA0 + 8'(b), txq[b]);
    chk("fifo empty", 8'h01, {7'h0, src_ready});
    fw(1'b1, 3'h2, 8'h06);
    usbepm_host_model_inst.send_tok(2'h1, 3'h2);
    @(posedge clock);
    host_timeout <= 1'b1;
    @(posedge clock);
    host_timeout <= 1'b0;
    h0 = hs_n;
    usbepm_host_model_inst.send_tok(2'h1, 3'h2);
    usbepm_host_model_inst.send_ack();
    repeat (4) @(posedge clock);
    chk("after timeout", 8'h01, 8'(hs_n - h0));
    chk("mode after timeout", 8'h16, ep_mode_flat[23:16]);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("second reset", 8'h00, {7'h0, |ep_mode_flat});
    finish_test();
  end
endmodule
